// >>> eau_addr_calc.sv
// Address arithmetic for the memory operand modes
`default_nettype none
module eau_addr_calc
  import eau_pkg::*;
(
  // Operands in, address out
  eau_calc_if.calc cif
);
  wire logic [31:0] idx_sized;
  wire logic [31:0] idx_scaled;
  wire logic [31:0] disp8;
  wire logic [31:0] disp16;
  wire logic [31:0] step;
  wire logic [31:0] pre_addr;

  // Index size, scale and displacement extension
  assign idx_sized = cif.ext0[EXT_SIZE_BIT] ? cif.index : {{16{cif.index[15]}}, cif.index[15:0]}; // RULE15
  assign idx_scaled = idx_sized << cif.ext0[10:9]; // RULE16
  assign disp8 = {{24{cif.ext0[7]}}, cif.ext0[7:0]};
  assign disp16 = {{16{cif.ext0[15]}}, cif.ext0}; // RULE11

  // Step by size; a byte through the stack pointer keeps word alignment
  assign step = (cif.size == SIZE_LONG) ? 32'h00000004 :
                (cif.size == SIZE_WORD) ? 32'h00000002 :
                (cif.regf == SP_REG) ? 32'h00000002 : 32'h00000001; // RULE9 RULE10
  assign pre_addr = cif.base - step; // RULE10
  assign cif.new_an = (cif.mode == MODE_PRE) ? pre_addr : cif.base + step; // RULE9

  // Operand address per mode
  assign cif.addr = (cif.mode == MODE_PRE) ? pre_addr :
                    (cif.mode == MODE_DISP) ? cif.base + disp16 : // RULE11
                    (cif.mode == MODE_INDEX && !cif.ext0[EXT_FULL_BIT]) ? cif.base + disp8 + idx_scaled : // RULE12
                    (cif.mode == MODE_INDEX) ? cif.base + cif.bd + idx_scaled : // RULE17
                    cif.base; // RULE19
endmodule
`default_nettype wire

// >>> eau_calc_if.sv
// Signals between the sequencing logic and the address arithmetic
`default_nettype none
interface eau_calc_if;
  logic [2:0] mode;
  logic [2:0] regf;
  logic [1:0] size;
  logic [31:0] base;
  logic [31:0] index;
  logic [15:0] ext0;
  logic [31:0] bd;
  logic [31:0] addr;
  logic [31:0] new_an;
  modport calc (input mode, regf, size, base, index, ext0, bd, output addr, new_an);
  modport user (output mode, regf, size, base, index, ext0, bd, input addr, new_an);
endinterface
`default_nettype wire

// >>> eau_core.sv
// Effective address unit: operand location, control registers, space codes
`default_nettype none
module eau_core
  import eau_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Control register move requests
  input wire logic creg_req,
  input wire logic creg_write,
  input wire logic [1:0] creg_sel,
  input wire logic [31:0] creg_wdata,
  output logic creg_ack,
  output logic creg_priv_fault,
  output logic [31:0] creg_rdata,
  // Current status word
  output logic [15:0] psw_out,
  // Operand specifier requests from the sequencer
  input wire logic ea_req,
  input wire logic [5:0] ea_spec,
  input wire logic [1:0] ea_size,
  input wire logic ea_write,
  input wire logic ea_jump,
  input wire logic [31:0] ea_pc,
  output logic ea_busy,
  // Register file read ports
  output logic [2:0] rf_base_idx,
  output logic [3:0] rf_index_idx,
  input wire logic [31:0] rf_base_val,
  input wire logic [31:0] rf_index_val,
  // Extension word fetch
  output logic ext_req,
  output logic [31:0] ext_addr,
  output logic [2:0] ext_space,
  input wire logic ext_ack,
  input wire logic [15:0] ext_data,
  // Operand result
  output logic ea_done,
  output logic [31:0] ea_addr,
  output logic [2:0] ea_space,
  output logic [3:0] ea_be,
  output logic ea_in_reg,
  output logic [3:0] ea_reg_idx,
  output logic ea_fault,
  output logic ea_unsupported,
  output logic [1:0] ea_ext_count,
  // Address register update
  output logic an_wr_en,
  output logic [2:0] an_wr_idx,
  output logic [31:0] an_wr_data
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_sync;
  wire logic rst_n;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [15:0] processor_status_word;
  logic [2:0] source_space_code;
  logic [2:0] destination_space_code;
  wire logic supervisor;
  wire logic priv_block;
  wire logic [31:0] creg_rd_mux;

  assign supervisor = processor_status_word[PSW_SUPER_BIT];
  // Only the condition byte is open at user level
  assign priv_block = !supervisor && (creg_sel != CSEL_CCR); // RULE2
  // Reads: undefined and unstored bits come back zero
  assign creg_rd_mux = (creg_sel == CSEL_PSW) ? {16'h0000, processor_status_word} : // RULE1 RULE3
                       (creg_sel == CSEL_CCR) ? {24'h000000, processor_status_word[7:0]} : // RULE3
                       (creg_sel == CSEL_SFC) ? {29'h00000000, source_space_code} : // RULE4
                       {29'h00000000, destination_space_code}; // RULE4

  // Writes store defined bits only; upper condition byte is dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      processor_status_word <= PSW_RESET;
      source_space_code <= SPACE_RESET;
      destination_space_code <= SPACE_RESET;
    end else if (creg_req && creg_write && !priv_block) begin
      if (creg_sel == CSEL_PSW) processor_status_word <= creg_wdata[15:0] & PSW_DEFINED; // RULE1
      else if (creg_sel == CSEL_CCR) processor_status_word[7:0] <= creg_wdata[7:0] & PSW_DEFINED[7:0]; // RULE3
      else if (creg_sel == CSEL_SFC) source_space_code <= creg_wdata[2:0]; // RULE4
      else destination_space_code <= creg_wdata[2:0]; // RULE4
    end
  end

  // One-cycle answer to each control request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      creg_ack <= 1'b0;
      creg_priv_fault <= 1'b0;
      creg_rdata <= 32'h00000000;
    end else begin
      creg_ack <= creg_req;
      creg_priv_fault <= creg_req && priv_block; // RULE2
      creg_rdata <= (creg_req && !creg_write && !priv_block) ? creg_rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) psw_out <= PSW_RESET;
    else psw_out <= processor_status_word;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand specifier decode
  eau_state_e state;
  eau_state_e next_state;
  logic [2:0] mode;
  logic [2:0] regf;
  logic [1:0] size;
  logic op_write;
  logic op_jump;
  logic [31:0] pc;
  logic [15:0] ext_word [3];
  logic [1:0] ext_cnt;
  wire logic [2:0] req_mode;
  wire logic [2:0] req_regf;
  wire logic req_needs_ext;
  wire logic [1:0] ext_total;
  wire logic fetch_last;
  wire logic [2:0] prog_space;
  wire logic [2:0] data_space;

  // Mode and register subfields of the request
  assign req_mode = ea_spec[5:3]; // RULE7
  assign req_regf = ea_spec[2:0]; // RULE7
  assign req_needs_ext = (req_mode == MODE_DISP) || (req_mode == MODE_INDEX); // RULE20
  // Full format adds one or two base displacement words
  assign ext_total = !(mode == MODE_INDEX && ext_word[0][EXT_FULL_BIT]) ? 2'h1 :
                     (ext_word[0][EXT_BD_HI:EXT_BD_LO] == BD_LONG) ? 2'h3 :
                     (ext_word[0][EXT_BD_HI:EXT_BD_LO] == BD_WORD) ? 2'h2 : 2'h1; // RULE17 RULE20
  assign fetch_last = ext_ack && (ext_cnt != 2'h0) && (ext_cnt + 2'h1 >= ext_total);
  assign prog_space = supervisor ? SPC_SUPER_PROG : SPC_USER_PROG;
  assign data_space = supervisor ? SPC_SUPER_DATA : SPC_USER_DATA;

  // Sequencing: fetch extensions, wait for register values, compute
  always_comb begin
    next_state = state;
    case (state)
      EAU_IDLE: begin
        if (ea_req && req_needs_ext && !ea_pc[0]) next_state = EAU_FETCH;
        else if (ea_req) next_state = EAU_WAIT;
      end
      EAU_FETCH: begin
        // One word ends the fetch unless a full format names a base displacement
        if (ext_ack && ext_cnt == 2'h0 &&
            !(mode == MODE_INDEX && ext_data[EXT_FULL_BIT] && ext_data[EXT_BD_HI:EXT_BD_LO] inside {BD_WORD, BD_LONG}))
          next_state = EAU_WAIT;
        else if (fetch_last) next_state = EAU_WAIT;
      end
      EAU_WAIT: next_state = EAU_CALC;
      EAU_CALC: next_state = EAU_IDLE;
      default: next_state = EAU_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) state <= EAU_IDLE;
    else state <= next_state;
  end

  // Request capture and extension word collection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= MODE_DREG;
      regf <= 3'h0;
      size <= SIZE_BYTE;
      op_write <= 1'b0;
      op_jump <= 1'b0;
      pc <= 32'h00000000;
      ext_cnt <= 2'h0;
      for (int i = 0; i < 3; i++) ext_word[i] <= 16'h0000;
    end else if (state == EAU_IDLE && ea_req) begin
      mode <= req_mode;
      regf <= req_regf;
      size <= ea_size;
      op_write <= ea_write;
      op_jump <= ea_jump;
      pc <= ea_pc;
      ext_cnt <= 2'h0;
      for (int i = 0; i < 3; i++) ext_word[i] <= 16'h0000;
    end else if (state == EAU_FETCH && ext_ack) begin
      ext_word[ext_cnt] <= ext_data; // RULE20
      ext_cnt <= ext_cnt + 2'h1;
      pc <= pc + 32'h00000002;
    end
  end

  // Extension fetch port, program space
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_req <= 1'b0;
      ext_addr <= 32'h00000000;
      ext_space <= SPC_USER_PROG;
    end else begin
      ext_req <= (next_state == EAU_FETCH);
      ext_addr <= (state == EAU_IDLE) ? ea_pc : (ext_ack ? pc + 32'h00000002 : pc);
      ext_space <= prog_space; // RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file addressing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rf_base_idx <= 3'h0;
      rf_index_idx <= 4'h0;
      ea_busy <= 1'b0;
    end else begin
      if (state == EAU_IDLE && ea_req) rf_base_idx <= req_regf;
      if (state == EAU_FETCH && ext_ack && ext_cnt == 2'h0) rf_index_idx <= ext_data[15:12]; // RULE14
      ea_busy <= (next_state != EAU_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address arithmetic
  eau_calc_if cif ();
  wire logic [31:0] bd_val;
  wire logic [31:0] calc_addr;
  wire logic is_reg_direct;
  wire logic is_special;
  wire logic misaligned;
  wire logic [2:0] op_space;
  wire logic [3:0] lane_be;
  wire logic [3:0] reg_sel;

  // Base displacement: word is sign-extended, long is two words high first
  assign bd_val = (ext_word[0][EXT_BD_HI:EXT_BD_LO] == BD_LONG) ? {ext_word[1], ext_word[2]} :
                  (ext_word[0][EXT_BD_HI:EXT_BD_LO] == BD_WORD) ? {{16{ext_word[1][15]}}, ext_word[1]} :
                  32'h00000000; // RULE17
  assign cif.mode = mode;
  assign cif.regf = regf;
  assign cif.size = size;
  assign cif.base = rf_base_val;
  assign cif.index = rf_index_val;
  assign cif.ext0 = ext_word[0];
  assign cif.bd = bd_val;
  assign calc_addr = cif.addr;

  eau_addr_calc u_calc (
    .cif(cif)
  );

  // Register direct, special selector and alignment checks
  assign is_reg_direct = (mode == MODE_DREG) || (mode == MODE_AREG); // RULE18
  assign is_special = (mode == MODE_SPECIAL); // RULE21
  assign reg_sel = {mode == MODE_AREG, regf}; // RULE18
  assign misaligned = pc[0] || (!is_reg_direct && size != SIZE_BYTE && calc_addr[0]); // RULE6 RULE22
  // Jumps through a brief or full index go to program space, writes to data space
  assign op_space = (mode == MODE_INDEX && op_jump && !op_write) ? prog_space : data_space; // RULE8 RULE13
  // Big-endian lanes: lane 3 carries the byte at the lowest address
  assign lane_be = (size == SIZE_LONG) ? 4'hF :
                   (size == SIZE_WORD) ? (calc_addr[1] ? 4'h3 : 4'hC) :
                   (4'h8 >> calc_addr[1:0]); // RULE5

  ////////////////////////////////////////////////////////////////////////////
  // Result registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ea_done <= 1'b0;
      ea_addr <= 32'h00000000;
      ea_space <= SPC_USER_DATA;
      ea_be <= 4'h0;
      ea_in_reg <= 1'b0;
      ea_reg_idx <= 4'h0;
      ea_fault <= 1'b0;
      ea_unsupported <= 1'b0;
      ea_ext_count <= 2'h0;
    end else begin
      ea_done <= (state == EAU_CALC);
      if (state == EAU_CALC) begin
        ea_addr <= (is_reg_direct || is_special) ? 32'h00000000 : calc_addr; // RULE19
        ea_space <= op_space; // RULE8
        ea_be <= (is_reg_direct || is_special || misaligned) ? 4'h0 : lane_be; // RULE22
        ea_in_reg <= is_reg_direct; // RULE18
        ea_reg_idx <= is_reg_direct ? reg_sel : 4'h0;
        ea_fault <= !is_reg_direct && !is_special && misaligned; // RULE22
        ea_unsupported <= is_special; // RULE21
        ea_ext_count <= ext_cnt;
      end
    end
  end

  // Address register update for postincrement and predecrement
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      an_wr_en <= 1'b0;
      an_wr_idx <= 3'h0;
      an_wr_data <= 32'h00000000;
    end else begin
      an_wr_en <= (state == EAU_CALC) && (mode == MODE_POST || mode == MODE_PRE) && !misaligned; // RULE9 RULE10
      an_wr_idx <= regf;
      an_wr_data <= cif.new_an; // RULE9 RULE10
    end
  end
endmodule
`default_nettype wire

// >>> eau_core_asserts.sv
// Concurrent checks on the effective address unit ports
`default_nettype none
module eau_core_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Control register bus
  input wire logic creg_req,
  input wire logic creg_write,
  input wire logic [1:0] creg_sel,
  input wire logic creg_ack,
  input wire logic creg_priv_fault,
  input wire logic [31:0] creg_rdata,
  input wire logic [15:0] psw_out,
  // Operand requests and results
  input wire logic ea_req,
  input wire logic [5:0] ea_spec,
  input wire logic ea_busy,
  input wire logic ea_done,
  input wire logic ea_in_reg,
  input wire logic ea_fault,
  input wire logic ea_unsupported,
  input wire logic [3:0] ea_be,
  input wire logic ext_req,
  input wire logic [2:0] ext_space
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Accepted requests of the register direct and special groups
  sequence s_direct;
    ea_req && !ea_busy && ea_spec[5:4] == 2'h0;
  endsequence
  sequence s_special;
    ea_req && !ea_busy && ea_spec[5:3] == 3'h7;
  endsequence
  // Direct result: no fetch for two cycles, then a register result
  sequence s_direct_result;
    !ext_req [*2] ##1 (ea_done && ea_in_reg && ea_be == 4'h0);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_ack_follows: assert property (creg_req |=> creg_ack) else $error("control ack missing");
  a_psw_undef_zero: assert property ((psw_out & ~16'hE71F) == 16'h0000)
    else $error("undefined status bits set");
  a_user_refused: assert property (creg_req && creg_sel != 2'h1 && !psw_out[13] &&
    !$past(creg_req && creg_write) |=> creg_priv_fault) else $error("user access not refused");
  a_cond_open: assert property (creg_req && creg_sel == 2'h1 |=> !creg_priv_fault)
    else $error("condition byte refused");
  a_fault_data_zero: assert property (creg_priv_fault |-> creg_rdata == 32'h0)
    else $error("refused access returned data");
  a_cond_upper_zero: assert property (creg_req && !creg_write && creg_sel == 2'h1
    |=> creg_rdata[31:8] == 24'h0) else $error("condition byte upper bits set");
  a_space_upper_zero: assert property (creg_req && !creg_write && creg_sel[1]
    |=> creg_rdata[31:3] == 29'h0) else $error("space code upper bits set");
  a_direct_result: assert property (s_direct |=> s_direct_result)
    else $error("register direct result wrong");
  a_special_flag: assert property (s_special |-> ##3 (ea_done && ea_unsupported))
    else $error("special mode not flagged");
  a_fetch_program: assert property (ext_req |-> ext_space == 3'h2 || ext_space == 3'h6)
    else $error("fetch not in program space");
  a_fault_no_lanes: assert property (ea_done && ea_fault |-> ea_be == 4'h0)
    else $error("faulted access has lanes");
  a_done_single: assert property (ea_done |=> !ea_done) else $error("done longer than one cycle");
endmodule
bind eau_core eau_core_asserts i_eau_core_asserts (.*);
`default_nettype wire

// >>> eau_mem_model.sv
// Register file and extension word source beside the unit
`default_nettype none
module eau_mem_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register file
  input wire logic [2:0] rf_base_idx,
  input wire logic [3:0] rf_index_idx,
  output logic [31:0] rf_base_val,
  output logic [31:0] rf_index_val,
  input wire logic an_wr_en,
  input wire logic [2:0] an_wr_idx,
  input wire logic [31:0] an_wr_data,
  // Extension word fetch
  input wire logic ext_req,
  input wire logic [31:0] ext_addr,
  output logic ext_ack,
  output logic [15:0] ext_data,
  input wire logic [1:0] stall
);
  logic [31:0] regs [16];
  logic [15:0] words [$];
  logic [31:0] seen [$];
  int cnt;
  // Register values follow the registered indices
  assign rf_base_val = regs[{1'b1, rf_base_idx}];
  assign rf_index_val = regs[rf_index_idx];
  // Answer a fetch after a stall; data toggles whenever not acknowledged
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_ack <= 1'b0;
      ext_data <= 16'hA5A5;
      cnt <= 0;
    end else if (ext_req && !ext_ack && cnt >= stall) begin
      ext_ack <= 1'b1;
      ext_data <= words.pop_front();
      seen.push_back(ext_addr);
      cnt <= 0;
    end else begin
      ext_ack <= 1'b0;
      ext_data <= ~ext_data;
      cnt <= ext_req ? cnt + 1 : 0;
    end
  end
  // Address register write-back
  always @(posedge ref_clk) begin
    if (an_wr_en) regs[{1'b1, an_wr_idx}] <= an_wr_data;
  end
endmodule
`default_nettype wire

// >>> eau_pkg.sv
// Constants and types shared by the effective address unit
// Functional notes
// (RULE1) Status word is 16 bits, 11 defined; undefined bits read zero.
// (RULE2) Condition byte usable at both levels; other control registers supervisor only.
// (RULE3) Status accesses are words; condition byte upper half reads zero, writes ignored.
// (RULE4) Space code registers are 32 bits, only bits 2:0 stored, rest zero.
// (RULE5) Memory is big endian; most significant byte at the lowest address.
// (RULE6) Instruction, word and long-word accesses must sit on word boundaries.
// (RULE7) Operand specifier splits into a 3-bit mode and a 3-bit register field.
// (RULE8) Fetches use program space; operand writes and most reads use data space.
// (RULE9) Postincrement adds 1, 2 or 4 after use; stack byte adds 2.
// (RULE10) Predecrement subtracts 1, 2 or 4 before use; stack byte subtracts 2.
// (RULE11) Displacement mode adds a sign-extended 16-bit displacement to the register.
// (RULE12) Brief index sums base, sign-extended 8-bit displacement and scaled index.
// (RULE13) Brief index references are data space, except jumps which use program space.
// (RULE14) Extension bit 15 picks data or address index; bits 14:12 its number.
// (RULE15) Extension bit 11 picks sign-extended low word or full long index.
// (RULE16) Extension bits 10:9 scale the index by 1, 2, 4 or 8.
// (RULE17) Full index sums register, scaled index and sign-extended 16/32-bit base displacement.
// (RULE18) Register direct modes take the operand from a register, no memory access.
// (RULE19) Plain indirect uses the address register contents unchanged as the address.
// (RULE20) Extension words after the operation word are fetched and used for addresses.
// (RULE21) Mode 111 makes the register field a special-mode selector; the code ignores the field and flags every mode 111 request unsupported.
// (RULE22) Odd word, long or fetch addresses raise a fault instead of an access.
`default_nettype none
package eau_pkg;
  // Operand specifier modes
  localparam logic [2:0] MODE_DREG = 3'h0;
  localparam logic [2:0] MODE_AREG = 3'h1;
  localparam logic [2:0] MODE_IND = 3'h2;
  localparam logic [2:0] MODE_POST = 3'h3;
  localparam logic [2:0] MODE_PRE = 3'h4;
  localparam logic [2:0] MODE_DISP = 3'h5;
  localparam logic [2:0] MODE_INDEX = 3'h6;
  localparam logic [2:0] MODE_SPECIAL = 3'h7;
  // Operand sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  // Stack pointer register number
  localparam logic [2:0] SP_REG = 3'h7;
  // Extension word field positions
  localparam int EXT_DA_BIT = 15;
  localparam int EXT_SIZE_BIT = 11;
  localparam int EXT_FULL_BIT = 8;
  localparam int EXT_BD_HI = 5;
  localparam int EXT_BD_LO = 4;
  localparam logic [1:0] BD_WORD = 2'h2;
  localparam logic [1:0] BD_LONG = 2'h3;
  // Control register selectors
  localparam logic [1:0] CSEL_PSW = 2'h0;
  localparam logic [1:0] CSEL_CCR = 2'h1;
  localparam logic [1:0] CSEL_SFC = 2'h2;
  localparam logic [1:0] CSEL_DFC = 2'h3;
  // Status word layout
  localparam logic [15:0] PSW_DEFINED = 16'hE71F;
  localparam logic [15:0] PSW_RESET = 16'h2700;
  localparam int PSW_SUPER_BIT = 13;
  localparam logic [2:0] SPACE_RESET = 3'h0;
  // Address space codes
  localparam logic [2:0] SPC_USER_DATA = 3'h1;
  localparam logic [2:0] SPC_USER_PROG = 3'h2;
  localparam logic [2:0] SPC_SUPER_DATA = 3'h5;
  localparam logic [2:0] SPC_SUPER_PROG = 3'h6;
  // Control flow states
  typedef enum logic [2:0] {EAU_IDLE, EAU_FETCH, EAU_WAIT, EAU_CALC} eau_state_e;
endpackage
`default_nettype wire

// >>> tb_effective_address_unit.sv
// Self-checking bench for the effective address unit
`default_nettype none
module tb_effective_address_unit import eau_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = '0, resetn = '0, creg_req = '0, creg_write = '0, ea_req = '0, ea_write = '0, ea_jump = '0;
  logic [1:0] creg_sel = '0, ea_size = '0, stall = '0, ea_ext_count;
  logic [31:0] creg_wdata = '0, ea_pc = '0, creg_rdata, rf_base_val, rf_index_val, ext_addr, ea_addr, an_wr_data;
  logic [5:0] ea_spec = '0;
  logic creg_ack, creg_priv_fault, ea_busy, ext_req, ext_ack, ea_done, ea_in_reg, ea_fault, ea_unsupported, an_wr_en;
  logic [15:0] psw_out, ext_data, mpsw;
  logic [2:0] rf_base_idx, ext_space, ea_space, an_wr_idx, msfc, mdfc;
  logic [3:0] rf_index_idx, ea_be, ea_reg_idx;
  logic [31:0] lfsr = 32'hD093E2D9, v, mregs [16];
  int mismatches = 0, check_count = 0, cyc = 0;
  eau_core i_eau_core (.*);
  eau_mem_model i_eau_mem_model (.*);
  // Clock and hang limit
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Control register move, expectation from the register model
  task automatic creg(input logic wr, input logic [1:0] sel, input logic [31:0] wd);
    logic flt;
    logic [31:0] e;
    flt = !mpsw[13] && sel != 2'h1;
    e = sel == 2'h0 ? mpsw & 16'hE71F : sel == 2'h1 ? mpsw[7:0] : sel == 2'h2 ? msfc : mdfc;
    if (flt || wr) e = '0;
    if (!flt && wr) begin
      case (sel)
        2'h0: mpsw = wd[15:0] & 16'hE71F;
        2'h1: mpsw[7:0] = wd[7:0] & 8'h1F;
        2'h2: msfc = wd[2:0];
        default: mdfc = wd[2:0];
      endcase
    end
    @(posedge ref_clk);
    creg_req <= 1'b1;
    creg_write <= wr;
    creg_sel <= sel;
    creg_wdata <= wd;
    @(posedge ref_clk);
    creg_req <= 1'b0;
    #1;
    chk_val(creg_ack, 1'b1);
    chk_val(creg_priv_fault, flt);
    chk_val(creg_rdata, e);
  endtask
  // Operand request, expectation from the address model
  task automatic run_ea(input logic [2:0] m, r, input logic [1:0] sz, input logic jump_instruction, input logic [31:0] pc,
    input logic [15:0] e0, e1, e2);
    logic [31:0] b, ix, a, step, nv;
    logic [15:0] ew [3];
    logic [3:0] be;
    logic flt, upd, prog;
    int cnt, n;
    ew = '{e0, e1, e2};
    b = mregs[{1'b1, r}];
    step = sz == 2'h2 ? 32'h4 : sz == 2'h1 || r == 3'h7 ? 32'h2 : 32'h1;
    ix = mregs[e0[15:12]];
    if (!e0[11]) ix = {{16{ix[15]}}, ix[15:0]};
    ix = ix << e0[10:9];
    cnt = m == 3'h5 || m == 3'h6;
    a = m == 3'h2 || m == 3'h3 ? b : m == 3'h4 ? b - step : m == 3'h5 ? b + {{16{e0[15]}}, e0} : '0;
    if (m == 3'h6 && !e0[8]) a = b + {{24{e0[7]}}, e0[7:0]} + ix;
    if (m == 3'h6 && e0[8]) begin
      cnt = e0[5:4] == 2'h3 ? 3 : e0[5:4] == 2'h2 ? 2 : 1;
      a = b + ix + (cnt == 3 ? {e1, e2} : cnt == 2 ? {{16{e1[15]}}, e1} : '0);
    end
    flt = m > 3'h1 && m < 3'h7 && (a[0] && sz != 2'h0 || m > 3'h4 && pc[0]);
    if (m > 3'h4 && pc[0]) cnt = 0;
    upd = (m == 3'h3 || m == 3'h4) && !flt;
    nv = m == 3'h3 ? b + step : a;
    prog = m == 3'h6 && jump_instruction;
    be = flt || m < 3'h2 || m == 3'h7 ? 4'h0 : sz == 2'h0 ? 4'h8 >> a[1:0] : sz == 2'h1 ? (a[1] ? 4'h3 : 4'hC) : 4'hF;
    for (int k = 0; k < cnt; k++) i_eau_mem_model.words.push_back(ew[k]);
    i_eau_mem_model.seen.delete();
    @(posedge ref_clk);
    ea_req <= 1'b1;
    ea_spec <= {m, r};
    ea_size <= sz;
    ea_jump <= jump_instruction;
    ea_pc <= pc;
    ea_write <= lfsr[3] && !jump_instruction;
    @(posedge ref_clk);
    ea_req <= 1'b0;
    n = 0;
    while (ea_done !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      #1;
      if (n == 0) chk_val(ea_busy, 1'b1);
      n++;
    end
    chk_val(n < 60, 1'b1);
    chk_val(ea_busy, 1'b0);
    chk_val(ea_fault, flt);
    chk_val(ea_unsupported, m == 3'h7);
    chk_val(ea_ext_count, cnt);
    chk_val(ea_in_reg, m < 3'h2);
    if (m < 3'h2) chk_val(ea_reg_idx, {m[0], r});
    if (m > 3'h1 && m < 3'h7 && !flt) chk_val(ea_addr, a);
    if (m > 3'h1 && m < 3'h7 && !flt) chk_val(ea_space, {mpsw[13], prog, !prog});
    if (sz != 2'h2 || !a[1]) chk_val(ea_be, be);
    chk_val(an_wr_en, upd);
    if (upd) chk_val({an_wr_idx, an_wr_data}, {r, nv});
    if (upd) mregs[{1'b1, r}] = nv;
    chk_val(i_eau_mem_model.seen.size(), cnt);
    for (int k = 0; k < cnt; k++) chk_val(i_eau_mem_model.seen[k], pc + 2 * k);
    // Let the register write-back land before the next register change
    @(posedge ref_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (int k = 0; k < 16; k++) begin
      mregs[k] = rnd();
      i_eau_mem_model.regs[k] = mregs[k];
    end
    {mpsw, msfc, mdfc} = {16'h2700, 6'h00};
    repeat (10) @(posedge ref_clk);
    chk_val({psw_out, ext_space, ea_space}, {16'h2700, 3'h2, 3'h1});
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    creg(1'b1, 2'h0, 32'hFFFFFFFF);
    creg(1'b0, 2'h0, 32'h0);
    for (int k = 2; k < 4; k++) creg(1'b1, k[1:0], 32'hFFFFFFF9 + k);
    for (int k = 2; k < 4; k++) creg(1'b0, k[1:0], 32'h0);
    creg(1'b1, 2'h1, 32'hFFFFFF15);
    creg(1'b0, 2'h1, 32'h0);
    creg(1'b0, 2'h0, 32'h0);
    creg(1'b1, 2'h0, 32'h00002700);
    for (int k = 0; k < 4; k++) run_ea(3'h3 + k[0], k[1] ? 3'h7 : 3'h2, 2'h0, 1'b0, 32'h100, '0, '0, '0);
    run_ea(3'h7, 3'h4, 2'h1, 1'b0, 32'h200, '0, '0, '0);
    run_ea(3'h5, 3'h1, 2'h1, 1'b0, 32'h201, '0, '0, '0);
    for (int i = 0; i < 90; i++) begin
      v = rnd();
      stall <= v[1:0];
      mregs[v[5:2]] = rnd();
      i_eau_mem_model.regs[v[5:2]] = mregs[v[5:2]];
      run_ea(v[8:6] == 3'h7 ? 3'h6 : v[8:6], v[18:16], v[11:10] == 2'h3 ? 2'h2 : v[11:10], v[9] && v[8:6] > 3'h5,
        rnd() & 32'hFFFFFFFE, rnd(), rnd(), rnd());
    end
    creg(1'b1, 2'h0, 32'h0);
    for (int k = 0; k < 4; k++) creg(k[0], k[1:0] ^ 2'h1, 32'h12);
    run_ea(3'h2, 3'h3, 2'h1, 1'b0, 32'h300, '0, '0, '0);
    run_ea(3'h6, 3'h3, 2'h0, 1'b1, 32'h300, 16'h1000, '0, '0);
    repeat (2) @(posedge ref_clk);
    #1;
    chk_val(psw_out, mpsw);
    close_out();
  end
endmodule
`default_nettype wire
